/* File: design/pll_control_registers.sv */
/*
  Control register bank of an integer-N synthesizer, loaded over a
  three-wire serial write port (clock, data, latch enable).
  Assumes the serial pins are asynchronous to mclk_i and that the serial
  clock runs well below a quarter of mclk_i; PD tick, window and analog
  lock inputs come from logic on mclk_i.
*/
//
// Functional notes
// - Prescaler code 01 is 16/17, 10 is 32/33, 11 is 64/65, and 00 is never to be used.
// - The reference divider is a 14-bit count from 4 to 16383; 0 to 3 are never to be used.
// - Lock-count select 00, 01, 10, 11 gives thresholds 7, 15, 31 and 63.
// - With boost enable low the boost current and duration are ignored; high, both apply.
// - Pump tri-state low keeps the pumps active; high turns the pump output off.
// - Pump polarity low is positive and high is negative, for both pump currents.
// - Lock mode low selects digital lock detect and high selects analog lock detect.
// - Boost current stays on for duration times the PD period, then turns off.
// - Bit D1 of the aux word drives the second aux output.
// - Bit D0 of the aux word drives the first aux output.
// - Function and aux words take effect at once, independently of the others.
// - Divider and pump words are buffered and applied only on the next A/B write.
`timescale 1ns/10ps
`default_nettype none
module pll_control_registers
  import pll_ctrl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic ser_latch_i,
  input wire logic pd_tick_i,
  input wire logic pd_in_window_i,
  input wire logic analog_lock_i,
  output logic [1:0] prescaler_sel_o,
  output logic [13:0] ref_div_o,
  output logic [5:0] swallow_count_o,
  output logic [12:0] program_count_o,
  output logic commit_o,
  output logic [3:0] pump_current_o,
  output logic pump_enable_o,
  output logic pump_polarity_o,
  output logic boost_active_o,
  output logic lock_o,
  output logic aux_output_one_o,
  output logic aux_output_two_o
);

  // ****************************************************************
  // Serial pin synchronisers
  // ****************************************************************
  logic [2:0] sclk_q;
  logic [2:0] latch_q;
  logic [1:0] data_q;
  logic sclk_rise;
  logic latch_rise;

  // Two flops per pin; the third tap only feeds the edge detector
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sclk_q <= '0;
      latch_q <= '0;
      data_q <= '0;
    end else begin
      sclk_q <= {sclk_q[1:0], ser_clk_i};
      latch_q <= {latch_q[1:0], ser_latch_i};
      data_q <= {data_q[0], ser_data_i};
    end
  end

  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign latch_rise = latch_q[1] & ~latch_q[2];

  // ****************************************************************
  // Frame shifter
  // ****************************************************************
  logic [FRAME_W-1:0] shift;
  logic [FRAME_W-1:0] next_shift;
  logic [WORD_W-1:0] word;
  logic [ADDR_W-1:0] addr;

  // MSB first: twenty data bits, then four address bits
  always_comb begin
    next_shift = shift;
    if (sclk_rise) begin
      next_shift = {shift[FRAME_W-2:0], data_q[1]};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      shift <= '0;
    end else begin
      shift <= next_shift;
    end
  end

  assign word = shift[FRAME_W-1:ADDR_W];
  assign addr = shift[ADDR_W-1:0];

  // ****************************************************************
  // Word storage and commit
  // ****************************************************************
  func_cfg_t func_cfg;
  func_cfg_t next_func_cfg;
  div_cfg_t div_buf;
  div_cfg_t next_div_buf;
  div_cfg_t div_act;
  div_cfg_t next_div_act;
  pump_cfg_t pump_buf;
  pump_cfg_t next_pump_buf;
  pump_cfg_t pump_act;
  pump_cfg_t next_pump_act;
  ab_cfg_t ab_act;
  ab_cfg_t next_ab_act;
  logic [1:0] aux;
  logic [1:0] next_aux;
  logic next_commit;
  div_cfg_t div_word;
  pump_cfg_t pump_word;
  func_cfg_t func_word;

  assign func_word = word[FUNC_LSB +: FUNC_W];
  assign div_word = word[DIV_LSB +: DIV_W];
  assign pump_word = '{boost_pump_current: word[PUMP_BOOST_LSB +: PUMP_FIELD_W],
                       normal_pump_current: word[PUMP_NORM_LSB +: PUMP_FIELD_W]};

  // Decode the latched frame; unknown addresses are dropped
  always_comb begin
    next_func_cfg = func_cfg;
    next_div_buf = div_buf;
    next_div_act = div_act;
    next_pump_buf = pump_buf;
    next_pump_act = pump_act;
    next_ab_act = ab_act;
    next_aux = aux;
    next_commit = 1'b0;
    if (latch_rise) begin
      case (addr)
        ADDR_FUNC: begin
          next_func_cfg = func_word;
        end
        ADDR_AUX: begin
          next_aux = {word[AUX_TWO_BIT], word[AUX_ONE_BIT]};
        end
        ADDR_DIV: begin
          // A prohibited code would stall the dividers, so it never reaches the buffer
          if (div_word.prescaler_sel != PRE_PROHIBITED && div_word.ref_div >= REF_DIV_MIN) begin
            next_div_buf = div_word;
          end
        end
        ADDR_PUMP: begin
          next_pump_buf = pump_word;
        end
        ADDR_AB: begin
          next_ab_act = word[AB_LSB +: AB_W];
          next_div_act = div_buf;
          next_pump_act = pump_buf;
          next_commit = 1'b1;
        end
        default: begin
          next_commit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      func_cfg <= FUNC_RESET;
      div_buf <= DIV_RESET;
      div_act <= DIV_RESET;
      pump_buf <= PUMP_RESET;
      pump_act <= PUMP_RESET;
      ab_act <= AB_RESET;
      aux <= '0;
      commit_o <= 1'b0;
    end else begin
      func_cfg <= next_func_cfg;
      div_buf <= next_div_buf;
      div_act <= next_div_act;
      pump_buf <= next_pump_buf;
      pump_act <= next_pump_act;
      ab_act <= next_ab_act;
      aux <= next_aux;
      commit_o <= next_commit;
    end
  end

  // ****************************************************************
  // Boost timer and lock filter
  // ****************************************************************
  logic boost_on;
  logic digital_lock;

  boost_timer u_boost_timer (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(func_cfg.boost_enable),
    .start_i(commit_o),
    .pd_tick_i(pd_tick_i),
    .duration_i(func_cfg.boost_duration),
    .active_o(boost_on)
  );

  lock_filter u_lock_filter (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .pd_tick_i(pd_tick_i),
    .in_window_i(pd_in_window_i),
    .threshold_i(lock_threshold(func_cfg.lock_count_sel)),
    .locked_o(digital_lock)
  );

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  logic [3:0] next_pump_current;
  logic next_lock;

  // Boost current only while the timer runs; the lock source follows mode
  always_comb begin
    next_pump_current = boost_on ? pump_act.boost_pump_current
                                 : pump_act.normal_pump_current;
    next_lock = func_cfg.lock_detect_mode ? analog_lock_i : digital_lock;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      prescaler_sel_o <= DIV_RESET.prescaler_sel;
      ref_div_o <= DIV_RESET.ref_div;
      swallow_count_o <= '0;
      program_count_o <= '0;
      pump_current_o <= '0;
      pump_enable_o <= 1'b0;
      pump_polarity_o <= 1'b0;
      boost_active_o <= 1'b0;
      lock_o <= 1'b0;
      aux_output_one_o <= 1'b0;
      aux_output_two_o <= 1'b0;
    end else begin
      prescaler_sel_o <= div_act.prescaler_sel;
      ref_div_o <= div_act.ref_div;
      swallow_count_o <= ab_act.swallow_count;
      program_count_o <= ab_act.program_count;
      pump_current_o <= next_pump_current;
      pump_enable_o <= ~func_cfg.pump_tristate;
      pump_polarity_o <= func_cfg.pump_polarity;
      boost_active_o <= boost_on;
      lock_o <= next_lock;
      aux_output_one_o <= aux[0];
      aux_output_two_o <= aux[1];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Aux pins follow their word two edges after the latch is seen
  a_aux_write_drives: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    latch_rise && addr == ADDR_AUX |-> ##2
    aux_output_two_o == $past(word[AUX_TWO_BIT], 2) &&
    aux_output_one_o == $past(word[AUX_ONE_BIT], 2))
    else $error("aux pins not updated");
  // Function bits reach the pump pins with no commit in between
  a_func_write_now: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    latch_rise && addr == ADDR_FUNC |-> ##2
    pump_enable_o == !$past(func_word.pump_tristate, 2) &&
    pump_polarity_o == $past(func_word.pump_polarity, 2))
    else $error("function word not immediate");
  // A divider write alone must not move the live dividers
  a_div_held_back: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    latch_rise && addr == ADDR_DIV |=> $stable(div_act))
    else $error("divider applied early");
  // An A/B write carries the buffered divider word to the pins
  a_commit_applies: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    latch_rise && addr == ADDR_AB |-> ##2 commit_o == 1'b0 &&
    ref_div_o == $past(div_buf.ref_div, 2) &&
    prescaler_sel_o == $past(div_buf.prescaler_sel, 2))
    else $error("commit lost");
  // The buffer never holds a prohibited divider setting
  a_no_bad_ref: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    div_buf.ref_div >= REF_DIV_MIN && div_buf.prescaler_sel != PRE_PROHIBITED)
    else $error("prohibited divider buffered");
  // Two disabled cycles leave only the normal current on the pump
  a_pump_select: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !func_cfg.boost_enable ##1 !func_cfg.boost_enable |=>
    pump_current_o == $past(pump_act.normal_pump_current))
    else $error("boost current used while disabled");
  // Analog mode passes the lock input through one register
  a_lock_source: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    func_cfg.lock_detect_mode |=> lock_o == $past(analog_lock_i))
    else $error("lock source wrong");
  // Digital mode passes the filter result through one register
  a_lock_digital: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !func_cfg.lock_detect_mode |=> lock_o == $past(digital_lock))
    else $error("digital lock source wrong");

endmodule : pll_control_registers
`default_nettype wire

/* File: design/pll_ctrl_pkg.sv */
/*
  Shared constants and types of the synthesizer control register bank:
  serial frame layout, word addresses, field positions, prohibited-value
  limits, lock-detect thresholds and the packed structs that carry words.
  Assumes a single clock domain; no timing figures are held here.
*/
package pll_ctrl_pkg;

  // ****************************************************************
  // Serial frame
  // ****************************************************************
  localparam int WORD_W = 20;
  localparam int ADDR_W = 4;
  localparam int FRAME_W = 24;

  // ****************************************************************
  // Word addresses
  // ****************************************************************
  localparam logic [3:0] ADDR_AB = 4'h1;
  localparam logic [3:0] ADDR_PUMP = 4'h2;
  localparam logic [3:0] ADDR_DIV = 4'h3;
  localparam logic [3:0] ADDR_FUNC = 4'h4;
  localparam logic [3:0] ADDR_AUX = 4'h5;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int AB_LSB = 0;
  localparam int AB_W = 19;
  localparam int FUNC_LSB = 0;
  localparam int FUNC_W = 19;
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 16;
  localparam int PUMP_NORM_LSB = 0;
  localparam int PUMP_BOOST_LSB = 6;
  localparam int PUMP_FIELD_W = 4;
  localparam int AUX_ONE_BIT = 0;
  localparam int AUX_TWO_BIT = 1;

  // ****************************************************************
  // Codes, limits and reset values
  // ****************************************************************
  localparam logic [1:0] PRE_PROHIBITED = 2'h0;
  localparam logic [1:0] PRE_DIV16 = 2'h1;
  localparam logic [1:0] PRE_DIV32 = 2'h2;
  localparam logic [1:0] PRE_DIV64 = 2'h3;
  localparam logic [13:0] REF_DIV_MIN = 14'h0004;
  localparam logic [5:0] LOCK_CNT_7 = 6'h07;
  localparam logic [5:0] LOCK_CNT_15 = 6'h0F;
  localparam logic [5:0] LOCK_CNT_31 = 6'h1F;
  localparam logic [5:0] LOCK_CNT_63 = 6'h3F;
  localparam logic [12:0] DUR_ONE = 13'h0001;
  localparam logic [5:0] CNT_ONE = 6'h01;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [1:0] lock_count_sel;
    logic boost_enable;
    logic pump_tristate;
    logic pump_polarity;
    logic lock_detect_mode;
    logic [12:0] boost_duration;
  } func_cfg_t;

  typedef struct packed {
    logic [1:0] prescaler_sel;
    logic [13:0] ref_div;
  } div_cfg_t;

  typedef struct packed {
    logic [12:0] program_count;
    logic [5:0] swallow_count;
  } ab_cfg_t;

  typedef struct packed {
    logic [3:0] boost_pump_current;
    logic [3:0] normal_pump_current;
  } pump_cfg_t;

  localparam func_cfg_t FUNC_RESET = '0;
  localparam div_cfg_t DIV_RESET = '{prescaler_sel: PRE_DIV16, ref_div: REF_DIV_MIN};
  localparam ab_cfg_t AB_RESET = '0;
  localparam pump_cfg_t PUMP_RESET = '0;

  typedef enum logic {
    LOCK_HUNT = 1'b0,
    LOCK_HELD = 1'b1
  } lock_state_t;

  // Threshold for the digital lock filter
  function automatic logic [5:0] lock_threshold(input logic [1:0] sel);
    case (sel)
      2'h0: lock_threshold = LOCK_CNT_7;
      2'h1: lock_threshold = LOCK_CNT_15;
      2'h2: lock_threshold = LOCK_CNT_31;
      default: lock_threshold = LOCK_CNT_63;
    endcase
  endfunction : lock_threshold

endpackage : pll_ctrl_pkg

/* File: design/boost_timer.sv */
/*
  Fast-lockup timer: holds the boost pump current on for a programmed
  number of phase-detector cycles after each frequency commit.
  Assumes pd_tick_i is a one-cycle pulse on mclk_i, one per PD cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module boost_timer
  import pll_ctrl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic enable_i,
  input wire logic start_i,
  input wire logic pd_tick_i,
  input wire logic [12:0] duration_i,
  output logic active_o
);

  logic [12:0] count;
  logic [12:0] next_count;
  logic next_active;

  // Load on commit, count PD ticks, drop when the last one passes
  always_comb begin
    next_count = count;
    next_active = active_o;
    if (!enable_i) begin
      next_count = '0;
      next_active = 1'b0;
    end else if (start_i) begin
      next_count = duration_i;
      next_active = (duration_i != '0);
    end else if (active_o && pd_tick_i) begin
      next_count = count - DUR_ONE;
      next_active = (count != DUR_ONE);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      count <= '0;
      active_o <= 1'b0;
    end else begin
      count <= next_count;
      active_o <= next_active;
    end
  end

  a_boost_disabled_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !enable_i |=> !active_o) else $error("boost on while disabled");
  a_boost_restart_load: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    enable_i && start_i && duration_i != '0 |=> active_o && count == $past(duration_i))
    else $error("boost timer did not restart");
  a_boost_expiry: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    enable_i && !start_i && active_o && pd_tick_i && count == DUR_ONE |=> !active_o)
    else $error("boost did not end after last cycle");
  a_boost_holds_on: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    enable_i && !start_i && active_o && !pd_tick_i |=> active_o && $stable(count))
    else $error("boost dropped between ticks");

endmodule : boost_timer
`default_nettype wire

/* File: design/lock_filter.sv */
/*
  Digital lock-detect filter: counts consecutive in-window phase
  comparisons and declares lock at the selected threshold.
  Assumes pd_tick_i marks each comparison and in_window_i is valid with it.
*/
`timescale 1ns/10ps
`default_nettype none
module lock_filter
  import pll_ctrl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic pd_tick_i,
  input wire logic in_window_i,
  input wire logic [5:0] threshold_i,
  output logic locked_o
);

  lock_state_t state;
  lock_state_t next_state;
  logic [5:0] run;
  logic [5:0] next_run;

  // One miss clears the run; the threshold run declares lock
  always_comb begin
    next_state = state;
    next_run = run;
    case (state)
      LOCK_HUNT: begin
        if (pd_tick_i && !in_window_i) begin
          next_run = '0;
        end else if (pd_tick_i) begin
          next_run = run + CNT_ONE;
          if (run + CNT_ONE >= threshold_i) begin
            next_state = LOCK_HELD;
          end
        end
      end
      LOCK_HELD: begin
        if (pd_tick_i && !in_window_i) begin
          next_state = LOCK_HUNT;
          next_run = '0;
        end
      end
      default: begin
        next_state = LOCK_HUNT;
        next_run = '0;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state <= LOCK_HUNT;
      run <= '0;
      locked_o <= 1'b0;
    end else begin
      state <= next_state;
      run <= next_run;
      locked_o <= (next_state == LOCK_HELD);
    end
  end

  a_lock_drop_miss: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    pd_tick_i && !in_window_i |=> !locked_o) else $error("lock kept after miss");
  a_lock_needs_run: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(locked_o) |-> $past(run) + CNT_ONE >= $past(threshold_i))
    else $error("lock declared before threshold");

endmodule : lock_filter
`default_nettype wire

/* File: verif/serial_host.sv */
/*
  Host controller model for the three-wire serial write port.
  Assumes the bench clock on mclk_i; ser_clk idles low outside frames.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_host (
  input wire logic mclk_i,
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic ser_latch_o
);
  // ********
  // Frame driver
  // ********
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    ser_latch_o = 1'b0;
  end

  // Steps just after an edge, so pins never move on the sampling edge
  task automatic hold(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : hold

  // Four cycles per half period: above the three the synchroniser needs
  task automatic send(input logic [3:0] addr, input logic [19:0] data);
    logic [23:0] frame;
    frame = {data, addr}; // Data word first, then address, MSB first
    for (int i = 23; i >= 0; i--) begin
      ser_data_o = frame[i];
      hold(4);
      ser_clk_o = 1'b1;
      hold(4);
      ser_clk_o = 1'b0;
    end
    hold(4);
    ser_latch_o = 1'b1; // Latch only after the last bit
    hold(4);
    ser_latch_o = 1'b0;
    ser_data_o = ~frame[0]; // Frame over: no stale bit left on the line
    hold(4);
  endtask : send
endmodule : serial_host
`default_nettype wire

/* File: verif/tb_pll_control_registers.sv */
/*
  Self-checking bench of the synthesizer control register bank.
  Assumes serial_host for the write port; PD tick and lock inputs are
  driven here on mclk; the tick is one cycle wide, four cycles apart.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHECK(nm, want, got) \
  begin \
    check_count++; \
    if ((got) !== (want)) begin \
      num_errors++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, want, got); \
    end \
  end
module tb_pll_control_registers
  import pll_ctrl_pkg::*;
;
  // ********
  // Signals and instances
  // ********
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic pd_tick = 1'b0;
  logic pd_in_window = 1'b0;
  logic analog_lock = 1'b0;
  logic ser_clk;
  logic ser_data;
  logic ser_latch;
  logic [1:0] prescaler_sel;
  logic [13:0] ref_div;
  logic [5:0] swallow_count;
  logic [12:0] program_count;
  logic commit;
  logic [3:0] pump_current;
  logic pump_enable;
  logic pump_polarity;
  logic boost_active;
  logic lock;
  logic aux_one;
  logic aux_two;
  logic [1:0] exp_pre = PRE_DIV16;
  logic [13:0] exp_ref = REF_DIV_MIN;
  int num_errors = 0;
  int check_count = 0;
  int commits = 0;

  always #2 mclk = ~mclk;

  // Counting pulses catches a commit strobe held longer than one cycle
  always @(posedge mclk) if (commit === 1'b1) commits <= commits + 1;

  serial_host u_serial_host (
    .mclk_i(mclk), .ser_clk_o(ser_clk), .ser_data_o(ser_data), .ser_latch_o(ser_latch)
  );

  pll_control_registers u_pll_control_registers (
    .mclk_i(mclk), .sys_rst_i(sys_rst), .ser_clk_i(ser_clk), .ser_data_i(ser_data),
    .ser_latch_i(ser_latch), .pd_tick_i(pd_tick), .pd_in_window_i(pd_in_window),
    .analog_lock_i(analog_lock), .prescaler_sel_o(prescaler_sel), .ref_div_o(ref_div),
    .swallow_count_o(swallow_count), .program_count_o(program_count), .commit_o(commit),
    .pump_current_o(pump_current), .pump_enable_o(pump_enable),
    .pump_polarity_o(pump_polarity), .boost_active_o(boost_active), .lock_o(lock),
    .aux_output_one_o(aux_one), .aux_output_two_o(aux_two)
  );

  // ********
  // Helpers
  // ********
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle

  task automatic wr(input logic [3:0] a, input logic [19:0] d);
    u_serial_host.send(a, d);
  endtask : wr

  function automatic logic [19:0] fw(input logic [1:0] sel, input logic be, input logic tz,
                                     input logic pol, input logic md, input logic [12:0] dur);
    return {1'b0, sel, be, tz, pol, md, dur};
  endfunction : fw

  // One tick per four cycles; window level stays as last driven
  task automatic ticks(input int n, input logic win);
    repeat (n) begin
      pd_tick = 1'b1;
      pd_in_window = win;
      idle(1);
      pd_tick = 1'b0;
      idle(3);
    end
  endtask : ticks

  task automatic stop_test;
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  // ********
  // Scenarios
  // ********
  task automatic t_reset;
    idle(1);
    `CHECK("prescaler_sel", PRE_DIV16, prescaler_sel)
    `CHECK("ref_div", REF_DIV_MIN, ref_div)
  endtask : t_reset

  // Host writes every word once with legal values before relying on any
  task automatic t_init;
    wr(ADDR_PUMP, {10'h0, 4'hA, 2'h0, 4'h5});
    wr(ADDR_DIV, {4'h0, PRE_DIV16, REF_DIV_MIN});
    wr(ADDR_FUNC, fw(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 13'h0001));
    wr(ADDR_AUX, 20'h00000);
    wr(ADDR_AB, {1'b0, 13'h0100, 6'h3F});
    `CHECK("commits", 1, commits)
  endtask : t_init

  task automatic t_aux;
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_AUX, {18'h0, 2'(c)});
      `CHECK("aux_one", c[0], aux_one)
      `CHECK("aux_two", c[1], aux_two)
    end
    wr(4'h6, 20'h00000);
    wr(4'h0, 20'h00000);
    `CHECK("aux_one kept", 1'b1, aux_one)
    `CHECK("commits", 1, commits)
  endtask : t_aux

  task automatic t_divider;
    int c0;
    for (int p = 1; p < 4; p++) begin
      c0 = commits;
      wr(ADDR_DIV, {4'h0, 2'(p), (p == 3) ? 14'h3FFF : REF_DIV_MIN + 14'(p)});
      `CHECK("ref_div held", exp_ref, ref_div)
      exp_pre = 2'(p);
      exp_ref = (p == 3) ? 14'h3FFF : REF_DIV_MIN + 14'(p);
      wr(ADDR_AB, {1'b0, 13'h0100, 6'h3F});
      `CHECK("prescaler_sel", exp_pre, prescaler_sel)
      `CHECK("ref_div", exp_ref, ref_div)
      `CHECK("commits", c0 + 1, commits)
    end
    // Prohibited codes must leave the buffered word untouched
    wr(ADDR_DIV, {4'h0, PRE_PROHIBITED, 14'h0100});
    wr(ADDR_DIV, {4'h0, PRE_DIV16, 14'h0003});
    wr(ADDR_AB, {1'b0, 13'h0003, 6'h03});
    `CHECK("prescaler_sel", exp_pre, prescaler_sel)
    `CHECK("ref_div", exp_ref, ref_div)
    `CHECK("swallow_count", 6'h03, swallow_count)
    `CHECK("program_count", 13'h0003, program_count)
  endtask : t_divider

  task automatic t_pump;
    wr(ADDR_FUNC, fw(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 13'h0003));
    `CHECK("pump_enable", 1'b1, pump_enable)
    `CHECK("pump_polarity", 1'b0, pump_polarity)
    `CHECK("pump_current", 4'h5, pump_current)
    `CHECK("boost_active", 1'b0, boost_active)
    wr(ADDR_FUNC, fw(2'h0, 1'b0, 1'b1, 1'b1, 1'b0, 13'h0003));
    `CHECK("pump_enable", 1'b0, pump_enable)
    `CHECK("pump_polarity", 1'b1, pump_polarity)
  endtask : t_pump

  // Duration 3: a restart after two ticks must give three more ticks
  task automatic t_boost;
    wr(ADDR_FUNC, fw(2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 13'h0003));
    wr(ADDR_AB, {1'b0, 13'h0100, 6'h3F});
    `CHECK("boost_active", 1'b1, boost_active)
    `CHECK("pump_current", 4'hA, pump_current)
    ticks(2, 1'b1);
    `CHECK("boost_active", 1'b1, boost_active)
    wr(ADDR_AB, {1'b0, 13'h0100, 6'h3F});
    ticks(2, 1'b1);
    `CHECK("boost restarted", 1'b1, boost_active)
    ticks(1, 1'b1);
    `CHECK("boost_active", 1'b0, boost_active)
    `CHECK("pump_current", 4'h5, pump_current)
  endtask : t_boost

  task automatic t_lock;
    int n;
    for (int s = 0; s < 4; s++) begin
      n = (8 << s) - 1;
      wr(ADDR_FUNC, fw(2'(s), 1'b0, 1'b0, 1'b0, 1'b0, 13'h0001));
      ticks(1, 1'b0);
      ticks(n - 1, 1'b1);
      `CHECK("lock early", 1'b0, lock)
      ticks(1, 1'b1);
      `CHECK("lock", 1'b1, lock)
      ticks(1, 1'b0);
      `CHECK("lock dropped", 1'b0, lock)
    end
    wr(ADDR_FUNC, fw(2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 13'h0001));
    analog_lock = 1'b1;
    idle(3);
    `CHECK("analog lock", 1'b1, lock)
    analog_lock = 1'b0;
    idle(3);
    `CHECK("analog lock", 1'b0, lock)
  endtask : t_lock

  // ********
  // Sequence and watchdog
  // ********
  initial begin
    idle(4);
    sys_rst = 1'b0;
    t_reset;
    t_init;
    t_aux;
    t_divider;
    t_pump;
    t_boost;
    t_lock;
    stop_test;
  end

  // About 30 frames of 204 cycles plus the lock runs: 40000 is ample
  initial begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    stop_test;
  end
endmodule : tb_pll_control_registers
`default_nettype wire
